// ---- pkg/ssp_regs.vh ----
// Constants for the synchronous serial slave port.
`ifndef SSP_REGS_VH
`define SSP_REGS_VH
`define SSP_FIFO_DEPTH     32
`define SSP_FIFO_WIDTH     8
`define SSP_FREE_W         5
`define SSP_HI7_MIN_CYC    4
`define SSP_CLK_MIN_CYC    2
`define SSP_SEL_LEAD_CYC   5
`define SSP_STOP_SYNC_CYC  3
`define SSP_BITS           8
`define SSP_MODE_SPI       2'h0
`define SSP_MODE_ASYNC     2'h1
`define SSP_MODE_MANCH     2'h2
`endif

// ---- rtl/ssp_fifo.v ----
// Parameterised synchronous FIFO with valid and ready on both sides.
`timescale 1ns/1ps
module ssp_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 32,
  parameter AW    = 5
) (
  input  wire             clock,     // Core clock.
  input  wire             rst_n,     // Synchronous reset, active low.
  input  wire             flush,     // Empties the FIFO.
  input  wire [WIDTH-1:0] in_data,   // Write data.
  input  wire             in_valid,  // Write request.
  output wire             in_ready,  // Not full.
  output wire [WIDTH-1:0] out_data,  // Head word.
  output wire             out_valid, // Not empty.
  input  wire             out_ready, // Pop request.
  output wire [AW:0]      level      // Entries held.
);
  localparam [AW:0] FULL_LVL = DEPTH; // Fill count that means full.
  reg [WIDTH-1:0] mem [0:DEPTH-1]; // Storage array.
  reg [AW-1:0]    wp_q;            // Write pointer.
  reg [AW-1:0]    rp_q;            // Read pointer.
  reg [AW:0]      cnt_q;           // Fill count.
  wire            push;            // Accepted write.
  wire            pop;             // Accepted read.

  assign in_ready  = (cnt_q != FULL_LVL);
  assign out_valid = (cnt_q != {(AW+1){1'b0}});
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  assign out_data  = mem[rp_q];
  assign level     = cnt_q;

  // Storage writes need no reset; only pointers and count carry state.
  always @(posedge clock) begin
    if (push) begin
      mem[wp_q] <= in_data;
    end
  end

  // Pointer and count bookkeeping.
  always @(posedge clock) begin
    if (!rst_n || flush) begin
      wp_q  <= {AW{1'b0}};
      rp_q  <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wp_q <= wp_q + 1'b1;
      end
      if (pop) begin
        rp_q <= rp_q + 1'b1;
      end
      cnt_q <= cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end
endmodule // ssp_fifo

// ---- rtl/ssp_port.v ----
// Synchronous serial slave port: transmit holding, shift, receive and pin control.
// Behaviour
// - Next byte loaded during low clock of bit7.
// - Non-FIFO write overwrites waiting held byte.
// - FIFO writes need enable; free count reported.
// - Disabled transmitter leaves data pin undriven.
// - Async or Manchester drives stopped level instead.
// - Slave output pin floats when disabled or not selected.
// - Internal stop state flags reported for polling.
// - Receive abort mid-frame leaves data undefined.
// - Clock phase bit locked after first write.
`timescale 1ns/1ps
`include "ssp_regs.vh"
module ssp_port #(
  parameter FIFO_DEPTH = `SSP_FIFO_DEPTH,
  parameter AW         = `SSP_FREE_W
) (
  input  wire       clock,           // Core clock, 200 MHz.
  input  wire       rst_n,           // Synchronous reset, active low.
  input  wire       tx_enable_bit,   // Transmit enable.
  input  wire       rx_enable_bit,   // Receive enable.
  input  wire       fifo_en,         // Selects FIFO path for transmit data.
  input  wire [1:0] mode,            // Serial mode select.
  input  wire       stop_level,      // Stopped-state level from common_ctrl_one.
  input  wire       phase_wr,        // Write strobe for the clock phase bit.
  input  wire       phase_val,       // Value written to the clock phase bit.
  input  wire       init_restart,    // Restarts initialisation, unlocking phase.
  input  wire [7:0] wr_data,         // Transmit byte.
  input  wire       wr_valid,        // Transmit byte write strobe.
  output reg        wr_ready,        // FIFO accepts writes.
  input  wire       serial_clock_pin,// External serial clock.
  input  wire       slave_select_pin,// Slave select, active low.
  input  wire       rx_pin,          // Master data in.
  output reg        tx_data_pin,     // Transmit data output.
  output reg        tx_data_oe,      // High while the data pin is driven.
  output reg        slave_out_pin,   // Slave data output.
  output reg        slave_out_oe,    // High while the slave output is driven.
  output reg        tx_empty_request,// Holding register empty pulse.
  output reg [AW-1:0] tx_fifo_free_count, // Free FIFO entries, saturated.
  output reg [7:0]  rx_data_reg,     // Last received byte.
  output reg        rx_valid,        // Received byte pulse.
  output reg        tx_internal_state_flag, // Transmitter still active.
  output reg        rx_internal_state_flag, // Receiver still active.
  output reg        clock_phase_lock_bit    // Clock phase option.
);
  // Full FIFO depth at the width of the level count, for the free-count sum.
  localparam [AW:0] DEPTH_LVL = FIFO_DEPTH;
  // Two-flop synchronisers for external pins. The master clock is only
  // sampled, never used as a clock, so the whole port stays on one domain.
  reg [1:0] sck_s_q;                 // Serial clock synchroniser.
  reg [1:0] ss_s_q;                  // Slave select synchroniser.
  reg [1:0] rx_s_q;                  // Master data synchroniser.
  reg       sck_d_q;                 // Delayed synchronised clock.
  reg [7:0] tx_hold_reg;             // Transmit holding register.
  reg       hold_full_q;             // Holding register occupied.
  reg [7:0] tx_shift_reg;            // Transmit shifter.
  reg [3:0] tx_bits_q;               // Bits left in shifter.
  reg [7:0] rx_shift_q;              // Receive shifter.
  reg [3:0] rx_bits_q;               // Bits received.
  reg       phase_set_q;             // Phase already written once.
  reg [2:0] te_sync_q;               // Transmit enable delay chain.
  reg [2:0] re_sync_q;               // Receive enable delay chain.
  wire      rise = sck_s_q[1] & ~sck_d_q;
  wire      fall = ~sck_s_q[1] & sck_d_q;
  wire      sel  = ~ss_s_q[1];
  wire      aon  = (mode == `SSP_MODE_ASYNC) || (mode == `SSP_MODE_MANCH);
  wire      f_rdy;                   // FIFO has room.
  wire      f_vld;                   // FIFO holds a byte.
  wire [7:0] f_dat;                  // FIFO head byte.
  wire [AW:0] f_lvl;                 // FIFO fill level.
  wire [AW:0] f_free;                // Free entries, unsaturated.

  // Free entries saturate at the largest value the count field can show.
  // An empty FIFO therefore reads one less than its true room; software
  // only ever under-fills, which is the safe direction.
  function [AW-1:0] sat_free;
    input [AW:0] free;
    begin
      if (free[AW]) begin
        sat_free = {AW{1'b1}};
      end else begin
        sat_free = free[AW-1:0];
      end
    end
  endfunction

  assign f_free = DEPTH_LVL - f_lvl;
  wire      f_pop = fifo_en & f_vld & ~hold_full_q;
  wire      f_push = fifo_en & tx_enable_bit & wr_valid;

  ssp_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH), .AW(AW)) u_fifo (
    .clock(clock), .rst_n(rst_n), .flush(~tx_enable_bit),
    .in_data(wr_data), .in_valid(f_push), .in_ready(f_rdy),
    .out_data(f_dat), .out_valid(f_vld), .out_ready(f_pop), .level(f_lvl));

  // Pin synchronisers; first stage read only by second.
  always @(posedge clock) begin
    if (!rst_n) begin
      // Select resets to its idle high level so no false frame starts.
      sck_s_q <= 2'h0;
      ss_s_q  <= 2'h3;
      rx_s_q  <= 2'h0;
      sck_d_q <= 1'b0;
    end else begin
      sck_s_q <= {sck_s_q[0], serial_clock_pin};
      ss_s_q  <= {ss_s_q[0], slave_select_pin};
      rx_s_q  <= {rx_s_q[0], rx_pin};
      sck_d_q <= sck_s_q[1];
    end
  end

  // Holding and shift path. A direct write while full overwrites the held
  // byte; software must pace writes by the empty request.
  always @(posedge clock) begin
    if (!rst_n || !tx_enable_bit) begin
      // Clearing transmit enable empties the whole transmit path.
      hold_full_q      <= 1'b0;
      tx_hold_reg      <= 8'h00;
      tx_shift_reg     <= 8'h00;
      tx_bits_q        <= 4'h0;
      tx_empty_request <= 1'b0;
    end else begin
      tx_empty_request <= 1'b0;
      if (!fifo_en && wr_valid) begin
        tx_hold_reg <= wr_data;
        hold_full_q <= 1'b1;
      end else if (f_pop) begin
        tx_hold_reg <= f_dat;
        hold_full_q <= 1'b1;
      end
      if (sel && fall && tx_bits_q != 4'h0) begin
        tx_shift_reg <= {tx_shift_reg[6:0], 1'b0};
        tx_bits_q    <= tx_bits_q - 4'h1;
      end else if (tx_bits_q == 4'h0 && hold_full_q && !(wr_valid && !fifo_en)) begin
        // Load on an idle shifter; the low phase of bit 7 gives the slack.
        tx_shift_reg     <= tx_hold_reg;
        tx_bits_q        <= 4'h8;
        hold_full_q      <= 1'b0;
        tx_empty_request <= 1'b1;
      end
    end
  end

  // Receiver; aborting mid-frame leaves the partial data undefined.
  always @(posedge clock) begin
    if (!rst_n || !rx_enable_bit) begin
      // A partial byte is dropped; the last full byte is kept but may be
      // stale, so software must not trust it after an abort.
      rx_shift_q <= 8'h00;
      rx_bits_q  <= 4'h0;
      rx_valid   <= 1'b0;
      if (!rst_n) begin
        rx_data_reg <= 8'h00;
      end
    end else begin
      rx_valid <= 1'b0;
      if (sel && rise) begin
        rx_shift_q <= {rx_shift_q[6:0], rx_s_q[1]};
        if (rx_bits_q == 4'h7) begin
          rx_data_reg <= {rx_shift_q[6:0], rx_s_q[1]};
          rx_valid    <= 1'b1;
          rx_bits_q   <= 4'h0;
        end else begin
          rx_bits_q <= rx_bits_q + 4'h1;
        end
      end
    end
  end

  // Pins, phase lock, stop-state flags and free count.
  always @(posedge clock) begin
    if (!rst_n) begin
      // Both drivers start released so the lines float until enabled, the data line in SPI mode only.
      tx_data_pin            <= 1'b1;
      tx_data_oe             <= 1'b0;
      slave_out_pin          <= 1'b1;
      slave_out_oe           <= 1'b0;
      clock_phase_lock_bit   <= 1'b0;
      phase_set_q            <= 1'b0;
      te_sync_q              <= 3'h0;
      re_sync_q              <= 3'h0;
      tx_internal_state_flag <= 1'b0;
      rx_internal_state_flag <= 1'b0;
      tx_fifo_free_count     <= {AW{1'b0}};
      wr_ready               <= 1'b0;
    end else begin
      tx_data_oe    <= tx_enable_bit | aon;
      tx_data_pin   <= tx_enable_bit ? tx_shift_reg[7] : stop_level;
      slave_out_oe  <= tx_enable_bit & sel;
      slave_out_pin <= tx_shift_reg[7];
      if (init_restart) begin
        phase_set_q <= 1'b0;
      end else if (phase_wr && !phase_set_q) begin
        clock_phase_lock_bit <= phase_val;
        phase_set_q <= 1'b1;
      end
      te_sync_q <= {te_sync_q[1:0], tx_enable_bit};
      re_sync_q <= {re_sync_q[1:0], rx_enable_bit};
      tx_internal_state_flag <= |te_sync_q;
      rx_internal_state_flag <= |re_sync_q;
      wr_ready <= f_rdy & tx_enable_bit & fifo_en;
      // Registered so the count follows the FIFO one cycle late.
      tx_fifo_free_count <= sat_free(f_free);
    end
  end
endmodule // ssp_port

// ---- tb/ssp_port_monitor.sv ----
// Concurrent checks on the slave port pins and status outputs.
`timescale 1ns/1ps
module ssp_port_monitor (
  input wire       clock, rst_n, tx_enable_bit, rx_enable_bit, stop_level, // Inputs.
  input wire [1:0] mode,                                            // Mode select.
  input wire       phase_wr, init_restart, wr_ready, tx_data_pin, tx_data_oe, // Pins.
  input wire       slave_out_oe, tx_empty_request, rx_valid, clock_phase_lock_bit, // Outs.
  input wire       tx_internal_state_flag, rx_internal_state_flag   // Stop flags.
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  // Transmitter off in SPI mode, or off in a mode that parks the line at a level.
  sequence s_spi_off; !tx_enable_bit && mode == 2'h0; endsequence
  sequence s_park;
    !tx_enable_bit && (mode == 2'h1 || mode == 2'h2) && $stable(mode) && $stable(stop_level);
  endsequence
  reg wrote_q; // Phase bit already written; a restart clears it.
  always @(posedge clock) wrote_q <= (!rst_n || init_restart) ? 1'b0 : (wrote_q | phase_wr);
  a_tx_float_off: assert property (s_spi_off [*3] |-> !tx_data_oe)
    else $error("tx pin driven while off");
  a_miso_float_off: assert property (s_spi_off [*3] |-> !slave_out_oe)
    else $error("slave output driven while off");
  a_park_level: assert property (s_park [*3] |-> tx_data_oe && tx_data_pin == stop_level)
    else $error("parked level wrong");
  a_empty_pulse: assert property (tx_empty_request |=> !tx_empty_request)
    else $error("empty request too long");
  a_rx_quiet_off: assert property (!rx_enable_bit [*2] |-> !rx_valid)
    else $error("byte while receiver off");
  a_tx_flag_stop: assert property (!tx_enable_bit [*5] |-> !tx_internal_state_flag)
    else $error("tx stop flag late");
  a_rx_flag_stop: assert property (!rx_enable_bit [*5] |-> !rx_internal_state_flag)
    else $error("rx stop flag late");
  a_refuse_off: assert property (!tx_enable_bit [*2] |-> !wr_ready)
    else $error("ready while off");
  a_phase_locked: assert property (wrote_q && !init_restart && !$past(init_restart)
    |=> $stable(clock_phase_lock_bit)) else $error("phase bit changed");
endmodule // ssp_port_monitor
bind ssp_port ssp_port_monitor ssp_port_monitor_i (.*);

// ---- tb/ssp_master_model.sv ----
// Behavioural SPI master that clocks the slave port from outside.
`timescale 1ns/1ps
module ssp_master_model (
  output reg  serial_clock_pin, // Serial clock, still and low between frames.
  output reg  slave_select_pin, // Slave select, active low.
  output reg  rx_pin,           // Master data out.
  input  wire slave_out_pin     // Slave data in, z when not driven.
);
  initial begin
    serial_clock_pin = 1'b0;
    slave_select_pin = 1'b1;
    rx_pin = 1'b0;
  end
  // One byte MSB first; 32 ns halves keep each pulse over six core cycles.
  task xfer(input [7:0] mo, output [7:0] mi);
    integer b;
    begin
      slave_select_pin = 1'b0;
      #40;
      for (b = 7; b >= 0; b = b - 1) begin
        rx_pin = mo[b];
        #32 serial_clock_pin = 1'b1;
        mi[b] = slave_out_pin;
        #32 serial_clock_pin = 1'b0;
      end
      #40 slave_select_pin = 1'b1;
      rx_pin = ~rx_pin; // Released line shows no stale bit.
    end
  endtask
endmodule // ssp_master_model

// ---- tb/tb.sv ----
// Self-checking bench for the synchronous serial slave port.
`timescale 1ns/1ps
`define CHK(g, e) begin compares = compares + 1; if ((g) !== (e)) begin \
  miscompares = miscompares + 1; $display("MISMATCH t=%0t got %h exp %h", $time, g, e); end end
module tb;
  reg        clock = 1'b0, rst_n = 1'b0, tx_enable_bit = 1'b0, rx_enable_bit = 1'b0;
  reg        fifo_en = 1'b0, stop_level = 1'b0, phase_wr = 1'b0, phase_val = 1'b0;
  reg        init_restart = 1'b0, wr_valid = 1'b0;
  reg  [1:0] mode = 2'h0;
  reg  [7:0] wr_data = 8'h00, got;
  wire       serial_clock_pin, slave_select_pin, rx_pin, wr_ready, tx_data_pin, tx_data_oe;
  wire       slave_out_pin, slave_out_oe, tx_empty_request, rx_valid, clock_phase_lock_bit;
  wire       tx_internal_state_flag, rx_internal_state_flag;
  wire [4:0] tx_fifo_free_count;
  wire [7:0] rx_data_reg;
  integer    miscompares = 0, compares = 0, i, n;
  integer    empties = 0, used = 0; // Empty pulses seen and consumed.
  always #2.5 clock = ~clock;
  // Counts empty pulses so one that falls inside a frame is not missed.
  always @(posedge clock) if (tx_empty_request === 1'b1) empties <= empties + 1;
  ssp_port ssp_port_i (.*);
  ssp_master_model ssp_master_model_i (.serial_clock_pin(serial_clock_pin),
    .slave_select_pin(slave_select_pin), .rx_pin(rx_pin),
    .slave_out_pin(slave_out_oe ? slave_out_pin : 1'bz));
  task complete_run; begin
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  end endtask
  task wr(input [7:0] d); begin
    @(negedge clock) wr_data = d;
    wr_valid = 1'b1;
    @(negedge clock) wr_valid = 1'b0;
  end endtask
  // Bounded wait for the load into the shifter.
  task wait_empty; begin
    for (n = 0; n < 40 && empties <= used; n = n + 1) @(negedge clock);
    `CHK(empties > used, 1'b1)
    used = used + 1;
  end endtask
  task pw(input v); begin
    @(negedge clock) phase_val = v;
    phase_wr = 1'b1;
    @(negedge clock) phase_wr = 1'b0;
    @(negedge clock);
  end endtask
  task t_phase; begin
    pw(1'b1); `CHK(clock_phase_lock_bit, 1'b1)
    pw(1'b0); `CHK(clock_phase_lock_bit, 1'b1)
    @(negedge clock) init_restart = 1'b1;
    @(negedge clock) init_restart = 0;
    pw(1'b0); `CHK(clock_phase_lock_bit, 1'b0)
    $display("phase lock test done");
  end endtask
  // Third write lands on a full holding register and replaces it.
  task t_over; begin
    @(negedge clock) tx_enable_bit = 1'b1;
    rx_enable_bit = 1'b1;
    wr(8'h11); wait_empty;
    wr(8'h22); wr(8'h33);
    ssp_master_model_i.xfer(8'h3c, got); `CHK(got, 8'h11)
    `CHK(rx_data_reg, 8'h3c)
    wait_empty; ssp_master_model_i.xfer(8'hc3, got); `CHK(got, 8'h33)
    $display("overwrite test done");
  end endtask
  task t_fifo; begin
    @(negedge clock) tx_enable_bit = 1'b0;
    fifo_en = 1'b1;
    wr(8'hee); `CHK(wr_ready, 1'b0)
    @(negedge clock) tx_enable_bit = 1'b1;
    repeat (4) @(negedge clock); `CHK(tx_fifo_free_count, 5'h1f)
    for (i = 0; i < 40 && wr_ready === 1'b1; i = i + 1) begin wr(i[7:0]); @(negedge clock); end
    `CHK(wr_ready, 1'b0)
    `CHK(tx_fifo_free_count, 5'h00)
    for (n = 0; n < i; n = n + 1) begin
      repeat (20) @(negedge clock); // Far side stalls between frames.
      ssp_master_model_i.xfer(8'h5a, got); `CHK(got, n[7:0])
    end
    repeat (4) @(negedge clock); `CHK(tx_fifo_free_count, 5'h1f)
    $display("fifo test done");
  end endtask
  // Enables drop only between frames, so no byte is cut short.
  task t_off; begin
    @(negedge clock) tx_enable_bit = 1'b0;
    rx_enable_bit = 1'b0;
    for (i = 0; i < 5; i = i + 1) begin
      @(negedge clock) mode = 2'((i + 1) / 2);
      stop_level = i[0];
      repeat (5) @(negedge clock); `CHK(tx_data_oe, i != 0)
      if (i == 0) `CHK(slave_out_oe, 1'b0) else `CHK(tx_data_pin, stop_level)
      `CHK(tx_internal_state_flag | rx_internal_state_flag, 1'b0)
    end
    $display("disable test done");
  end endtask
  initial begin
    repeat (3) @(negedge clock);
    rst_n = 1'b1;
    @(negedge clock); `CHK(tx_data_oe | slave_out_oe, 1'b0)
    t_phase; t_over; t_fifo; t_off;
    complete_run;
  end
  initial begin
    #100000 miscompares = miscompares + 1;
    complete_run;
  end
endmodule // tb
